// File: shared/ices_pkg.sv
// Constants and types for the instruction subset executor
`default_nettype none
package ices_pkg;
  // Opcode patterns and their compare masks
  localparam logic [15:0] OP_CLEAR_FILE_INSTR = 16'h6a00;
  localparam logic [15:0] MSK_CLEAR_FILE_INSTR = 16'hfe00;
  localparam logic [15:0] OP_MULTIPLY_FILE_INSTR = 16'h0200;
  localparam logic [15:0] MSK_MULTIPLY_FILE_INSTR = 16'hfe00;
  localparam logic [15:0] OP_MULTIPLY_LITERAL_INSTR = 16'h0d00;
  localparam logic [15:0] MSK_MULTIPLY_LITERAL_INSTR = 16'hff00;
  localparam logic [15:0] OP_RELATIVE_CALL_INSTR = 16'hd800;
  localparam logic [15:0] MSK_RELATIVE_CALL_INSTR = 16'hf800;
  localparam logic [15:0] OP_CLEAR_WATCHDOG_INSTR = 16'h0004;
  localparam logic [15:0] OP_RESET = 16'h00ff;
  // Field positions inside an instruction word
  localparam int ACC_BIT = 8;
  localparam int OFS_MSB = 10;
  // Addressing limits
  localparam logic [7:0] IDX_LIMIT = 8'h5f;
  localparam logic [7:0] ACC_SPLIT = 8'h80;
  localparam logic [3:0] ACC_HI_BANK = 4'hf;
  // Reset values
  localparam logic [15:0] PROD_RST = 16'h0000;
  localparam logic [7:0] WDT_RST = 8'h00;
  localparam logic [2:0] WDT_POST_RST = 3'h0;
  // Memory geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  // Sequencer states
  typedef enum logic {ST_RUN, ST_CALL2} ices_state_t;
endpackage : ices_pkg
`default_nettype wire

// File: shared/ices_mem_if.sv
// Data memory port bundle between the executor and its RAM
`default_nettype none
interface ices_mem_if #(
  parameter int AW = 12,
  parameter int DW = 8
);
  logic wr_en; // Write strobe
  logic [AW-1:0] wr_addr; // Write address
  logic [DW-1:0] wr_data; // Write data
  logic [AW-1:0] rd_addr; // Read address, data one cycle later
  logic [DW-1:0] rd_data; // Registered read data
  modport ctrl (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
  modport mem (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface : ices_mem_if
`default_nettype wire

// File: core/ices_data_mem.sv
// File register RAM with registered read port
`default_nettype none
module ices_data_mem #(
  parameter int AW = 12,
  parameter int DW = 8
) (
  input wire logic clk_in,
  ices_mem_if.mem port_if
);
  // Storage; not touched by any reset, as real RAM would not be
  logic [DW-1:0] ram_q [2**AW];

  // Write side
  always_ff @(posedge clk_in) begin
    if (port_if.wr_en) begin
      ram_q[port_if.wr_addr] <= port_if.wr_data;
    end
  end

  // Read side; a write on the same edge is seen one cycle later
  always_ff @(posedge clk_in) begin
    port_if.rd_data <= ram_q[port_if.rd_addr];
  end
endmodule : ices_data_mem
`default_nettype wire

// File: core/ices_exec.sv
// Executor for clear, clear-watchdog, multiply, relative call and reset
`default_nettype none
module ices_exec
  import ices_pkg::*;
#(
  parameter int PC_W = 21,
  parameter int WDT_W = 8,
  parameter int POST_W = 3
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic instr_valid_in, // Instruction word presented
  input wire logic [15:0] instr_in, // Fetched instruction word
  input wire logic [7:0] w_in, // Working register value
  input wire logic [7:0] bank_select_register_in, // Bank number
  input wire logic ext_set_en_in, // Extended instruction set on
  input wire logic [ices_pkg::ADDR_W-1:0] index_base_in, // Offset base
  input wire logic host_wr_in, // Other core write to file RAM
  input wire logic [ices_pkg::ADDR_W-1:0] host_addr_in,
  input wire logic [7:0] host_data_in,
  output logic instr_ready_out, // Low during call second cycle
  output logic [PC_W-1:0] pc_out, // Program counter
  output logic stack_push_out, // One-cycle push strobe
  output logic [PC_W-1:0] return_stack_top_out, // Pushed address
  output logic [7:0] product_high_byte_out,
  output logic [7:0] product_low_byte_out,
  output logic zero_flag_out, // Zero status flag
  output logic timeout_status_bit_out, // Active-low style status bit
  output logic powerdown_status_bit_out, // Active-low style status bit
  output logic [WDT_W-1:0] watchdog_counter_out,
  output logic [POST_W-1:0] wdt_post_out,
  output logic master_clear_reset_out, // One-cycle soft reset pulse
  output logic [7:0] host_rd_data_out // File RAM read data
);
  ices_state_t state_q; // Sequencer state
  logic [PC_W-1:0] pc_q;
  logic push_q;
  logic [PC_W-1:0] tos_q;
  logic [15:0] prod_q; // High byte in the upper half
  logic zero_q;
  logic to_q;
  logic pd_q;
  logic [WDT_W-1:0] wdt_q;
  logic [POST_W-1:0] post_q;
  logic master_clear_reset_q;
  logic ready_q; // Instruction port ready, mirrors the sequencer
  logic multiply_file_instr_pend_q; // File multiply waiting for its operand
  logic [7:0] w_hold_q; // W captured for the pending multiply

  ices_mem_if #(.AW(ADDR_W), .DW(DATA_W)) mem_if ();

  // Opcode match under a mask
  function automatic logic op_is(input logic [15:0] ins,
                                 input logic [15:0] op,
                                 input logic [15:0] msk);
    return (ins & msk) == op;
  endfunction : op_is

  // Effective file address from access bit and 8-bit field
  function automatic logic [ADDR_W-1:0] eff_addr(
    input logic acc, input logic [7:0] f, input logic [7:0] bank,
    input logic ext, input logic [ADDR_W-1:0] base);
    logic [ADDR_W-1:0] a;
    a = '0;
    if (acc) begin
      a = {bank[3:0], f};
    end else if (ext && f <= IDX_LIMIT) begin
      a = ADDR_W'(base + {4'h0, f});
    end else if (f < ACC_SPLIT) begin
      a = {4'h0, f};
    end else begin
      a = {ACC_HI_BANK, f}; // Upper access half is special space
    end
    return a;
  endfunction : eff_addr

  // Decode of the word in hand
  logic exec;
  logic dec_clear_file_instr, dec_multiply_file_instr, dec_multiply_literal_instr, dec_relative_call_instr, dec_clear_watchdog_instr, dec_rst;
  logic [ADDR_W-1:0] f_addr;
  logic [PC_W-1:0] pc_next;
  logic [PC_W-1:0] call_tgt;
  assign exec = instr_valid_in && (state_q == ST_RUN);
  assign dec_clear_file_instr = exec && op_is(instr_in, OP_CLEAR_FILE_INSTR, MSK_CLEAR_FILE_INSTR);
  assign dec_multiply_file_instr = exec && op_is(instr_in, OP_MULTIPLY_FILE_INSTR, MSK_MULTIPLY_FILE_INSTR);
  assign dec_multiply_literal_instr = exec && op_is(instr_in, OP_MULTIPLY_LITERAL_INSTR, MSK_MULTIPLY_LITERAL_INSTR);
  assign dec_relative_call_instr = exec && op_is(instr_in, OP_RELATIVE_CALL_INSTR, MSK_RELATIVE_CALL_INSTR);
  assign dec_clear_watchdog_instr = exec && (instr_in == OP_CLEAR_WATCHDOG_INSTR);
  assign dec_rst = exec && (instr_in == OP_RESET);
  assign f_addr = eff_addr(instr_in[ACC_BIT], instr_in[7:0],
                           bank_select_register_in, ext_set_en_in,
                           index_base_in);
  assign pc_next = PC_W'(pc_q + PC_W'(2));
  // Offset doubled and sign extended; range -1024..1023 words
  assign call_tgt = PC_W'(pc_next +
                    {{(PC_W-12){instr_in[OFS_MSB]}},
                     instr_in[OFS_MSB:0], 1'b0});

  // RAM hookup: clear wins the write port over the host
  assign mem_if.wr_en = dec_clear_file_instr || host_wr_in;
  assign mem_if.wr_addr = dec_clear_file_instr ? f_addr : host_addr_in;
  assign mem_if.wr_data = dec_clear_file_instr ? 8'h00 : host_data_in;
  // Read address follows the multiply, else the host
  assign mem_if.rd_addr = dec_multiply_file_instr ? f_addr : host_addr_in;

  ices_data_mem #(.AW(ADDR_W), .DW(DATA_W)) u_mem (
    .clk_in(clk_in),
    .port_if(mem_if)
  );

  // Sequencer: call holds the fetch one extra cycle
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q <= ST_RUN;
    end else if (dec_rst) begin
      state_q <= ST_RUN;
    end else begin
      unique case (state_q)
        ST_RUN: if (dec_relative_call_instr) state_q <= ST_CALL2;
        ST_CALL2: state_q <= ST_RUN;
      endcase
    end
  end

  // Ready flop; kept apart so the output has no decode behind it
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ready_q <= 1'b1;
    end else if (dec_rst) begin
      ready_q <= 1'b1;
    end else begin
      ready_q <= !dec_relative_call_instr;
    end
  end

  // Program counter and return stack push
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pc_q <= '0;
      tos_q <= '0;
      push_q <= 1'b0;
    end else if (dec_rst) begin
      pc_q <= '0;
      tos_q <= '0;
      push_q <= 1'b0;
    end else begin
      push_q <= dec_relative_call_instr;
      if (dec_relative_call_instr) begin
        tos_q <= pc_next;
        pc_q <= call_tgt;
      end else if (exec) begin
        pc_q <= pc_next;
      end
    end
  end

  // Pending file multiply; operand arrives next cycle from RAM
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      multiply_file_instr_pend_q <= 1'b0;
      w_hold_q <= 8'h00;
    end else begin
      multiply_file_instr_pend_q <= dec_multiply_file_instr;
      if (dec_multiply_file_instr) begin
        w_hold_q <= w_in; // W itself is never written here
      end
    end
  end

  // Product pair; a later literal multiply overrides an older result
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prod_q <= PROD_RST;
    end else if (dec_rst) begin
      prod_q <= PROD_RST;
    end else if (dec_multiply_literal_instr) begin
      prod_q <= 16'(w_in) * 16'(instr_in[7:0]);
    end else if (multiply_file_instr_pend_q) begin
      prod_q <= 16'(w_hold_q) * 16'(mem_if.rd_data);
    end
  end

  // Zero flag: only clear-file and the reset instruction touch it, multiplies never do
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      zero_q <= 1'b0;
    end else if (dec_rst) begin
      zero_q <= 1'b0;
    end else if (dec_clear_file_instr) begin
      zero_q <= 1'b1;
    end
  end

  // Watchdog counter with postscaler; free running between clears
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wdt_q <= WDT_RST;
      post_q <= WDT_POST_RST;
    end else if (dec_clear_watchdog_instr || dec_rst) begin
      wdt_q <= WDT_RST;
      post_q <= WDT_POST_RST;
    end else begin
      wdt_q <= WDT_W'(wdt_q + 1'b1);
      if (&wdt_q) begin
        post_q <= POST_W'(post_q + 1'b1);
      end
    end
  end

  // Time-out and power-down bits; only clear-watchdog and reset set them here
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      to_q <= 1'b1;
      pd_q <= 1'b1;
    end else if (dec_clear_watchdog_instr || dec_rst) begin
      to_q <= 1'b1;
      pd_q <= 1'b1;
    end
  end

  // Soft reset pulse for the rest of the core
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      master_clear_reset_q <= 1'b0;
    end else begin
      master_clear_reset_q <= dec_rst;
    end
  end

  // Outputs straight from flops
  assign instr_ready_out = ready_q;
  assign pc_out = pc_q;
  assign stack_push_out = push_q;
  assign return_stack_top_out = tos_q;
  assign product_high_byte_out = prod_q[15:8];
  assign product_low_byte_out = prod_q[7:0];
  assign zero_flag_out = zero_q;
  assign timeout_status_bit_out = to_q;
  assign powerdown_status_bit_out = pd_q;
  assign watchdog_counter_out = wdt_q;
  assign wdt_post_out = post_q;
  assign master_clear_reset_out = master_clear_reset_q;
  assign host_rd_data_out = mem_if.rd_data;

  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  sequence s_call_issue;
    dec_relative_call_instr;
  endsequence
  sequence s_call_done;
    !instr_ready_out ##1 instr_ready_out;
  endsequence

  a_clear_file_instr_zero_flag: assert property (dec_clear_file_instr |=> zero_flag_out)
    else $error("clear-file did not set zero flag");
  a_bank_sel_addr: assert property (dec_clear_file_instr && instr_in[ACC_BIT]
    |-> mem_if.wr_addr[11:8] == bank_select_register_in[3:0])
    else $error("bank select not used");
  a_index_addr: assert property (dec_clear_file_instr && !instr_in[ACC_BIT]
    && ext_set_en_in && instr_in[7:0] <= IDX_LIMIT
    |-> mem_if.wr_addr == ADDR_W'(index_base_in + instr_in[7:0]))
    else $error("indexed offset address wrong");
  a_wdt_clear: assert property (dec_clear_watchdog_instr |=> watchdog_counter_out == 0
    && wdt_post_out == 0 && timeout_status_bit_out
    && powerdown_status_bit_out)
    else $error("clear-watchdog effect wrong");
  a_multiply_literal_instr_prod: assert property (dec_multiply_literal_instr |=> {product_high_byte_out,
    product_low_byte_out} == $past(w_in) * $past(instr_in[7:0]))
    else $error("literal product wrong");
  a_multiply_file_instr_prod: assert property (dec_multiply_file_instr ##1 !dec_multiply_literal_instr
    |=> {product_high_byte_out, product_low_byte_out}
        == $past(w_hold_q) * $past(mem_if.rd_data))
    else $error("file product wrong");
  a_mul_flags: assert property ((dec_multiply_literal_instr || dec_multiply_file_instr) && !dec_rst
    |=> $stable(zero_flag_out))
    else $error("multiply changed a flag");
  a_relative_call_instr_push: assert property (s_call_issue |=> stack_push_out
    && return_stack_top_out == PC_W'($past(pc_q) + 2))
    else $error("call push wrong");
  a_relative_call_instr_cycles: assert property (s_call_issue |=> s_call_done)
    else $error("call not two cycles");
  a_soft_reset: assert property (dec_rst |=> master_clear_reset_out
    && pc_out == 0 && !zero_flag_out && instr_ready_out)
    else $error("software reset incomplete");
  a_one_cycle: assert property (dec_clear_file_instr || dec_multiply_literal_instr
    |=> instr_ready_out && pc_out == PC_W'($past(pc_q) + 2))
    else $error("single-cycle op stalled");
  a_call_refused: assert property (!instr_ready_out && instr_valid_in
    |=> $stable(pc_out) && $stable(prod_q))
    else $error("word taken during call second cycle");
  a_reset_pulse: assert property (dec_rst ##1 !dec_rst
    |=> !master_clear_reset_out)
    else $error("soft reset pulse too long");
endmodule : ices_exec
`default_nettype wire

// File: bench/cpu_instruction_subset_exec_test.sv
// Self-checking bench for the instruction subset executor
`default_nettype none
module cpu_instruction_subset_exec_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ices_pkg::*;
  logic clk, rst_n, vld, ext, hwr; // Clock, reset and strobes
  logic [15:0] instr; // Instruction word
  logic [7:0] w, bank, hdata; // Operand inputs
  logic [11:0] base, haddr; // Offset base, RAM port address
  logic rdy, push, zf, to_b, pd_b, master_clear_reset; // Single-bit results
  logic [20:0] pc, return_stack_top; // Program counter and pushed address
  logic [7:0] ph, pl, wdt, hrd; // Product pair, watchdog, RAM data
  logic [2:0] post; // Watchdog postscaler
  logic [7:0] rv; // Scratch for RAM reads
  int fail_count = 0;
  int checked = 0;
  ices_exec u_dut (.clk_in(clk), .rstn_in(rst_n), .instr_valid_in(vld),
    .instr_in(instr), .w_in(w), .bank_select_register_in(bank),
    .ext_set_en_in(ext), .index_base_in(base), .host_wr_in(hwr),
    .host_addr_in(haddr), .host_data_in(hdata), .instr_ready_out(rdy),
    .pc_out(pc), .stack_push_out(push), .return_stack_top_out(return_stack_top),
    .product_high_byte_out(ph), .product_low_byte_out(pl),
    .zero_flag_out(zf), .timeout_status_bit_out(to_b),
    .powerdown_status_bit_out(pd_b), .watchdog_counter_out(wdt),
    .wdt_post_out(post), .master_clear_reset_out(master_clear_reset),
    .host_rd_data_out(hrd));
  // Free-running 4 ns clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Single comparison point; four-state compare so X never matches
  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // Verdict and end of run
  task automatic summarize;
    if (fail_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  // One instruction; one-cycle kinds must step the PC by one word
  task automatic exec(input logic [15:0] word);
    logic [20:0] p0;
    p0 = pc;
    @(posedge clk);
    vld <= 1'b1;
    instr <= word;
    @(posedge clk);
    vld <= 1'b0;
    #1;
    if (word !== 16'h00ff) chk("pc", pc, p0 + 21'd2);
  endtask : exec
  // RAM write through the side port
  task automatic hw(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    hwr <= 1'b1;
    haddr <= a;
    hdata <= d;
    @(posedge clk);
    hwr <= 1'b0;
    #1;
  endtask : hw
  // RAM read; data is registered one cycle after the address
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge clk);
    haddr <= a;
    @(posedge clk);
    #1;
    d = hrd;
  endtask : rd
  // Multiplies: product pair, operands kept, flags left alone
  task automatic t_mul;
    exec(16'h0dc4);
    chk("prod", {ph, pl}, 16'had08);
    exec(16'h0d00);
    chk("prod0", {ph, pl}, 16'h0000);
    chk("zf", zf, 1'b0);
    exec(16'h6a05);
    hw(12'h3b5, 8'hb5);
    @(posedge clk);
    w <= 8'hc4;
    exec(16'h03b5);
    @(posedge clk);
    #1;
    chk("prodf", {ph, pl}, 16'h8a94);
    chk("zf1", zf, 1'b1);
    rd(12'h3b5, rv);
    chk("src", rv, 8'hb5);
  endtask : t_mul
  // Clear-file across access bank, bank register and high split
  task automatic t_clear_file_instr;
    hw(12'h005, 8'h5a);
    hw(12'h310, 8'h77);
    hw(12'h010, 8'h33);
    hw(12'hf90, 8'h44);
    exec(16'h6a05);
    chk("zf", zf, 1'b1);
    exec(16'h6b10);
    exec(16'h6a90);
    rd(12'h005, rv);
    chk("acc", rv, 8'h00);
    rd(12'h310, rv);
    chk("bank", rv, 8'h00);
    rd(12'h010, rv);
    chk("keep", rv, 8'h33);
    rd(12'hf90, rv);
    chk("hi", rv, 8'h00);
  endtask : t_clear_file_instr
  // Indexed offset only up to 5Fh with the extended set on
  task automatic t_index;
    hw(12'h25f, 8'h11);
    hw(12'h05f, 8'h22);
    hw(12'h060, 8'h33);
    @(posedge clk);
    ext <= 1'b1;
    exec(16'h6a5f);
    exec(16'h6a60);
    @(posedge clk);
    ext <= 1'b0;
    rd(12'h25f, rv);
    chk("idx", rv, 8'h00);
    rd(12'h05f, rv);
    chk("idxk", rv, 8'h22);
    rd(12'h060, rv);
    chk("edge", rv, 8'h00);
  endtask : t_index
  // Relative call; a word offered in the second cycle is refused
  task automatic t_relative_call_instr(input logic [10:0] n);
    logic [20:0] p0;
    logic [15:0] pr;
    p0 = pc;
    pr = {ph, pl};
    @(posedge clk);
    vld <= 1'b1;
    instr <= {5'b11011, n};
    @(posedge clk);
    instr <= 16'h0dff;
    #1;
    chk("tgt", pc, 21'(p0 + 21'd2 + {{9{n[10]}}, n, 1'b0}));
    chk("tos", return_stack_top, p0 + 21'd2);
    chk("push", {push, rdy}, 2'b10);
    @(posedge clk);
    vld <= 1'b0;
    #1;
    chk("push2", {push, rdy}, 2'b01);
    chk("held", {ph, pl}, pr);
  endtask : t_relative_call_instr
  // Clear-watchdog after the postscaler has moved
  task automatic t_clear_watchdog_instr;
    repeat (300) @(posedge clk);
    exec(16'h0004);
    chk("wdt", {wdt, post}, 11'h000);
    chk("topd", {to_b, pd_b}, 2'b11);
  endtask : t_clear_watchdog_instr
  // Software reset restores master-clear values, one-cycle pulse
  task automatic t_reset;
    exec(16'h0dc4);
    exec(16'h6a05);
    chk("pre", {ph, pl, zf}, 17'h12c21);
    exec(16'h00ff);
    chk("master_clear_reset", master_clear_reset, 1'b1);
    chk("regs_pc", pc, 21'h00000);
    chk("regs", {ph, pl, zf, to_b, pd_b, push}, 20'h00006);
    @(posedge clk);
    #1;
    chk("mclr0", master_clear_reset, 1'b0);
  endtask : t_reset
  // Hang guard, well beyond the few hundred cycles needed
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    summarize();
  end
  // Main sequence
  initial begin
    rst_n = 1'b0;
    vld = 1'b0;
    ext = 1'b0;
    hwr = 1'b0;
    instr = 16'h0000;
    w = 8'he2;
    bank = 8'h03;
    hdata = 8'h00;
    base = 12'h200;
    haddr = 12'h000;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("rst_pc", pc, 21'h00000);
    chk("rst", {ph, pl, zf, to_b, pd_b, rdy}, 20'h00007);
    t_mul();
    t_reset();
    t_clear_file_instr();
    t_index();
    t_relative_call_instr(11'h7ff);
    t_relative_call_instr(11'h3ff);
    t_relative_call_instr(11'h400);
    t_clear_watchdog_instr();
    summarize();
  end
endmodule : cpu_instruction_subset_exec_test
`default_nettype wire
